// File: tb/ahb_to_ahb_split_bridge_bench.sv
// self-checking bench for the ahb split bridge
`timescale 1ns/10ps
module ahb_to_ahb_split_bridge_bench;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic hwrite_in = 1'b0;
  logic hmastlock_in = 1'b0;
  logic prefetch_in = 1'b0;
  logic err = 1'b0;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h0;
  logic [2:0] hburst_in = 3'h0;
  logic [2:0] waits = 3'h0;
  logic [3:0] hmaster_in = 4'h0;
  logic [31:0] haddr_in = 32'h0;
  logic [31:0] hwdata_in = 32'h0;
  logic hready_out, mbusreq_out, mlock_out, mwrite_out, mgrant_in, mready_in, lock_seen;
  logic [1:0] hresp_out, mtrans_out, mresp_in;
  logic [2:0] msize_out, mburst_out, last_size;
  logic [15:0] hsplit_out;
  logic [31:0] hrdata_out, maddr_out, mwdata_out, mrdata_in, nbeats, last_addr, b;
  int n_mismatch = 0;
  int num_checks = 0;
  int split_cyc;
  hbb_bridge #(.FIFO_WORDS(8), .NMST(16)) i_dut (.clk_in, .sys_rst_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in, .hburst_in, .hwdata_in, .hmaster_in, .hmastlock_in,
    .hready_in(hready_out), .prefetch_in, .hready_out, .hresp_out, .hrdata_out, .hsplit_out,
    .mbusreq_out, .mlock_out, .maddr_out, .mtrans_out, .mwrite_out, .msize_out, .mburst_out,
    .mwdata_out, .mgrant_in, .mready_in, .mresp_in, .mrdata_in);
  hbb_slave_model i_model (.clk_in, .sys_rst_in, .busreq_in(mbusreq_out), .lock_in(mlock_out),
    .addr_in(maddr_out), .trans_in(mtrans_out), .write_in(mwrite_out), .size_in(msize_out),
    .waits_in(waits), .err_in(err), .grant_out(mgrant_in), .ready_out(mready_in),
    .resp_out(mresp_in), .rdata_out(mrdata_in), .nbeats_out(nbeats), .size_out(last_size),
    .addr_out(last_addr), .lock_seen_out(lock_seen));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one upstream transfer, address driven for one cycle once hready is seen high
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] sz, bu,
      input logic [3:0] m, input logic lk, pf, output logic [1:0] r, output logic [31:0] d,
      output int nw);
    int k;
    k = 0;
    @(negedge clk_in);
    while (hready_out !== 1'b1 && k < 50) begin
      k++;
      @(negedge clk_in);
    end
    {hsel_in, haddr_in, htrans_in, hwrite_in} = {1'b1, a, hbb_pkg::HTRANS_NSEQ, w};
    {hsize_in, hburst_in, hmaster_in, hmastlock_in, prefetch_in} = {sz, bu, m, lk, pf};
    @(negedge clk_in);
    {hsel_in, htrans_in, hmastlock_in, hwdata_in} = {1'b0, hbb_pkg::HTRANS_IDLE, 1'b0, ~a};
    // answer stands one cycle, so it is read mid-cycle
    r = hresp_out;
    nw = 0;
    while (hready_out !== 1'b1 && nw < 50) begin
      nw++;
      @(negedge clk_in);
    end
    if (r !== hbb_pkg::HRESP_SPLIT) r = hresp_out;
    d = hrdata_out;
  endtask
  task automatic wait_split(input int m, output int c);
    c = 0;
    while (hsplit_out[m] !== 1'b1 && c < 60) begin
      @(posedge clk_in);
      c++;
    end
  endtask
  task automatic wait_beats(input logic [31:0] n);
    int k;
    k = 0;
    while (nbeats < n && k < 80) begin
      @(posedge clk_in);
      k++;
    end
  endtask
  task automatic read_full(input logic [31:0] a, input logic [2:0] sz, bu, input logic [3:0] m,
      input logic pf, input logic [1:0] er);
    logic [1:0] r;
    logic [31:0] d;
    int nw;
    xfer(a, 1'b0, sz, bu, m, 1'b0, pf, r, d, nw);
    check("first read answer", r, hbb_pkg::HRESP_SPLIT);
    wait_split(m, split_cyc);
    check("split release", split_cyc < 60, 1);
    xfer(a, 1'b0, sz, bu, m, 1'b0, pf, r, d, nw);
    check("read answer", r, er);
    if (er === hbb_pkg::HRESP_OKAY) check("read data", d, a ^ 32'h5a5a0000);
  endtask
  task automatic t_single_read;
    b = nbeats;
    read_full(32'h100, hbb_pkg::HSIZE_WORD, hbb_pkg::HBURST_SINGLE, 4'h1, 1'b0, 2'h0);
    check("read latency", split_cyc <= 6, 1);
    check("read beats", nbeats - b, 1);
    check("read addr", last_addr, 32'h100);
  endtask
  task automatic t_narrow;
    logic [1:0] r;
    logic [31:0] d, a;
    int nw;
    for (int s = 0; s < 2; s++) begin
      a = 32'h201 + s;
      b = nbeats;
      read_full(a, s[2:0], hbb_pkg::HBURST_SINGLE, 4'h2, 1'b0, 2'h0);
      check("narrow read beats", nbeats - b, 1);
      check("narrow read size", {29'h0, last_size}, s[31:0]);
      b = nbeats;
      xfer(a, 1'b1, s[2:0], hbb_pkg::HBURST_SINGLE, 4'h2, 1'b0, 1'b0, r, d, nw);
      check("write answer", r, hbb_pkg::HRESP_OKAY);
      check("write waits", nw, 0);
      wait_beats(b + 32'h1);
      check("narrow write beats", nbeats - b, 1);
      check("narrow write size", {29'h0, last_size}, s[31:0]);
    end
  endtask
  task automatic t_wide;
    logic [1:0] r;
    logic [31:0] d;
    int nw;
    for (int s = 3; s < 6; s++) begin
      b = nbeats;
      xfer(32'h300, 1'b1, s[2:0], hbb_pkg::HBURST_SINGLE, 4'h2, 1'b0, 1'b0, r, d, nw);
      wait_beats(b + (32'h1 << (s - 2)));
      check("wide write beats", nbeats - b, 32'h1 << (s - 2));
      check("wide write size", last_size, hbb_pkg::HSIZE_WORD);
    end
    b = nbeats;
    read_full(32'h340, 3'h3, hbb_pkg::HBURST_SINGLE, 4'h2, 1'b0, 2'h0);
    check("wide read beats", nbeats - b, 2);
  endtask
  task automatic t_lock;
    logic [1:0] r;
    logic [31:0] d;
    int nw;
    check("no lock yet", lock_seen, 0);
    b = nbeats;
    xfer(32'h400, 1'b1, hbb_pkg::HSIZE_WORD, 3'h0, 4'h3, 1'b1, 1'b0, r, d, nw);
    check("locked write wait", nw, 1);
    wait_beats(b + 32'h1);
    check("down bus locked", lock_seen, 1);
    check("posted write data", mwdata_out, ~32'h400);
  endtask
  task automatic t_error_prefetch;
    logic [1:0] r;
    logic [31:0] d;
    int nw;
    err = 1'b1;
    read_full(32'h480, hbb_pkg::HSIZE_WORD, hbb_pkg::HBURST_SINGLE, 4'h3, 1'b0, 2'h1);
    err = 1'b0;
    // slow far side while prefetching
    waits = 3'h2;
    b = nbeats;
    read_full(32'h510, hbb_pkg::HSIZE_WORD, hbb_pkg::HBURST_INCR, 4'h4, 1'b1, 2'h0);
    check("prefetch beats", nbeats - b, 4);
    check("prefetch end", last_addr, 32'h51c);
    // collect the rest of the prefetched words so the buffer drains
    for (int k = 1; k < 4; k++) begin
      xfer(32'h510 + 32'(4 * k), 1'b0, hbb_pkg::HSIZE_WORD, hbb_pkg::HBURST_INCR, 4'h4, 1'b0,
        1'b1, r, d, nw);
      check("prefetch data", d, (32'h510 + 32'(4 * k)) ^ 32'h5a5a0000);
    end
    waits = 3'h0;
  endtask
  task automatic t_order;
    logic [1:0] r;
    logic [31:0] d;
    int nw, c;
    xfer(32'h600, 1'b0, hbb_pkg::HSIZE_WORD, 3'h0, 4'h5, 1'b0, 1'b0, r, d, nw);
    xfer(32'h604, 1'b0, hbb_pkg::HSIZE_WORD, 3'h0, 4'h6, 1'b0, 1'b0, r, d, nw);
    check("later master split", r, hbb_pkg::HRESP_SPLIT);
    wait_split(5, c);
    check("later master held", hsplit_out[6], 0);
    xfer(32'h600, 1'b0, hbb_pkg::HSIZE_WORD, 3'h0, 4'h5, 1'b0, 1'b0, r, d, nw);
    check("first master data", d, 32'h600 ^ 32'h5a5a0000);
    wait_split(6, c);
    check("later master released", c < 60, 1);
    xfer(32'h604, 1'b0, hbb_pkg::HSIZE_WORD, 3'h0, 4'h6, 1'b0, 1'b0, r, d, nw);
    if (r === hbb_pkg::HRESP_SPLIT) begin
      wait_split(6, c);
      xfer(32'h604, 1'b0, hbb_pkg::HSIZE_WORD, 3'h0, 4'h6, 1'b0, 1'b0, r, d, nw);
    end
    check("later master data", d, 32'h604 ^ 32'h5a5a0000);
  endtask
  initial begin
    repeat (6) @(negedge clk_in);
    sys_rst_in = 1'b0;
    t_single_read;
    t_narrow;
    t_wide;
    t_lock;
    t_error_prefetch;
    t_order;
    final_report;
  end
  // whole run is a few hundred cycles
  initial begin
    #(20000 * 5);
    n_mismatch++;
    final_report;
  end
endmodule

// File: tb/hbb_slave_model.sv
// downstream ahb slave and arbiter model for the bridge bench
`timescale 1ns/10ps
module hbb_slave_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // bridge master side
  input wire logic busreq_in,
  input wire logic lock_in,
  input wire logic [31:0] addr_in,
  input wire logic [1:0] trans_in,
  input wire logic write_in,
  input wire logic [2:0] size_in,
  // scenario control
  input wire logic [2:0] waits_in,
  input wire logic err_in,
  // answers and bookkeeping
  output logic grant_out,
  output logic ready_out,
  output logic [1:0] resp_out,
  output logic [31:0] rdata_out,
  output logic [31:0] nbeats_out,
  output logic [2:0] size_out,
  output logic [31:0] addr_out,
  output logic lock_seen_out
);
  logic pend_q, wr_q, err_q, stall;
  logic [2:0] wcnt_q;
  logic [31:0] a_q, last_q;
  // error takes two cycles as on a real slave
  assign stall = pend_q && (wcnt_q != 3'h0 || (err_in && !err_q));
  assign ready_out = !stall;
  assign resp_out = (pend_q && err_in && wcnt_q == 3'h0) ? hbb_pkg::HRESP_ERROR
                                                        : hbb_pkg::HRESP_OKAY;
  // idle bus shows the inverse of the last value, never a stale copy
  assign rdata_out = (pend_q && !wr_q) ? (a_q ^ 32'h5a5a0000) : ~last_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      grant_out <= 1'b0;
      {pend_q, wr_q, err_q, lock_seen_out} <= 4'h0;
      {wcnt_q, size_out} <= 6'h0;
      {a_q, last_q, addr_out, nbeats_out} <= 128'h0;
    end else begin
      grant_out <= busreq_in;
      if (stall && wcnt_q != 3'h0) wcnt_q <= wcnt_q - 3'h1;
      if (stall && wcnt_q == 3'h0) err_q <= 1'b1;
      if (!stall) begin
        err_q <= 1'b0;
        last_q <= rdata_out;
        if (pend_q && !err_in) nbeats_out <= nbeats_out + 32'h1;
        pend_q <= grant_out && trans_in[1];
        wr_q <= write_in;
        a_q <= addr_in;
        wcnt_q <= waits_in;
        if (grant_out && trans_in[1]) begin
          addr_out <= addr_in;
          size_out <= size_in;
          lock_seen_out <= lock_seen_out | lock_in;
        end
      end
    end
  end
endmodule

// File: verilog/hbb_bridge.sv
// one-way ahb to ahb bridge with split responses, prefetch and fcfs ordering
`timescale 1ns/10ps
module hbb_bridge #(
  parameter int FIFO_WORDS = 8,
  parameter int NMST = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // upstream slave side
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [2:0] hburst_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [3:0] hmaster_in,
  input wire logic hmastlock_in,
  input wire logic hready_in,
  input wire logic prefetch_in,
  output logic hready_out,
  output logic [1:0] hresp_out,
  output logic [31:0] hrdata_out,
  output logic [NMST-1:0] hsplit_out,
  // downstream master side
  output logic mbusreq_out,
  output logic mlock_out,
  output logic [31:0] maddr_out,
  output logic [1:0] mtrans_out,
  output logic mwrite_out,
  output logic [2:0] msize_out,
  output logic [2:0] mburst_out,
  output logic [31:0] mwdata_out,
  input wire logic mgrant_in,
  input wire logic mready_in,
  input wire logic [1:0] mresp_in,
  input wire logic [31:0] mrdata_in
);
  localparam int AW = $clog2(FIFO_WORDS);
  initial begin
    if (FIFO_WORDS < 1 || FIFO_WORDS > 16 || NMST != 16) begin
      $error("hbb_bridge: unsupported parameters");
    end
  end

  hbb_pkg::hbb_state_t st_q, st_d;
  hbb_pkg::hbb_req_t req_q, req_d, sav_q, sav_d;
  logic sav_v_q, sav_v_d;
  logic [31:0] buf_q [FIFO_WORDS];
  logic [AW:0] cnt_q, cnt_d, beats_q, beats_d, idx_q, idx_d;
  logic rd_v_q, rd_v_d, err_q, err_d;
  logic wlat_q, wlat_d;
  logic [15:0] queue_q, queue_d;
  logic [NMST-1:0] hsplit_d;
  logic hready_d, mreq_d, mlock_d, mwrite_d;
  logic [1:0] hresp_d, mtrans_d;
  logic [31:0] hrdata_d, maddr_d, mwdata_d;
  logic [2:0] msize_d, mburst_d;
  logic lk_q, lk_d;

  wire up_act = hsel_in && hready_in && htrans_in[1];
  wire owner = (hmaster_in == req_q.master);

  // beat count of the downstream transfer
  function automatic logic [AW:0] beat_count(input hbb_pkg::hbb_req_t r);
    logic [5:0] wide;
    logic [5:0] to_bnd;
    logic [5:0] n;
    wide = 6'(1) << ((r.size > hbb_pkg::HSIZE_WORD) ? (r.size - hbb_pkg::HSIZE_WORD) : 3'h0);
    to_bnd = 6'(hbb_pkg::BOUNDARY_WORDS) - 6'(r.addr[4:2]);
    n = 6'h01;
    if (r.burst == hbb_pkg::HBURST_SINGLE) begin
      n = wide;
    end else if (r.write) begin
      n = 6'(FIFO_WORDS);
    end else if (r.prefetch) begin
      n = (to_bnd < 6'(FIFO_WORDS)) ? to_bnd : 6'(FIFO_WORDS);
    end else begin
      n = wide;
    end
    if (n > 6'(FIFO_WORDS)) begin
      n = 6'(FIFO_WORDS);
    end
    return (AW + 1)'(n);
  endfunction

  always_comb begin
    st_d = st_q;
    req_d = req_q;
    sav_d = sav_q;
    sav_v_d = sav_v_q;
    cnt_d = cnt_q;
    beats_d = beats_q;
    idx_d = idx_q;
    rd_v_d = rd_v_q;
    err_d = err_q;
    wlat_d = 1'b0;
    queue_d = queue_q;
    lk_d = lk_q;
    hsplit_d = '0;
    hready_d = 1'b1;
    hresp_d = hbb_pkg::HRESP_OKAY;
    hrdata_d = hrdata_out;
    mreq_d = mbusreq_out;
    mlock_d = mlock_out;
    maddr_d = maddr_out;
    mtrans_d = hbb_pkg::HTRANS_IDLE;
    mwrite_d = mwrite_out;
    msize_d = msize_out;
    mburst_d = mburst_out;
    mwdata_d = mwdata_out;
    // write data beat follows the accepted address
    if (wlat_q) begin
      mwdata_d = hwdata_in;
    end
    case (st_q)
      hbb_pkg::ST_IDLE: begin
        if (up_act) begin
          req_d = '{haddr_in, hwrite_in, hsize_in, hburst_in, hmaster_in,
                    hmastlock_in, prefetch_in};
          if (hwrite_in) begin
            // posted write answered okay at once, locked ones one wait
            hready_d = !hmastlock_in;
            wlat_d = 1'b1;
            st_d = hbb_pkg::ST_WDATA;
          end else if (sav_v_q && rd_v_q && hmaster_in == sav_q.master) begin
            hready_d = 1'b1;
          end else begin
            hresp_d = hbb_pkg::HRESP_SPLIT;
            hready_d = 1'b0;
            st_d = hbb_pkg::ST_DREQ;
          end
          beats_d = beat_count(req_d);
          cnt_d = '0;
          idx_d = '0;
          lk_d = hmastlock_in;
        end
      end
      hbb_pkg::ST_WDATA: begin
        st_d = hbb_pkg::ST_DREQ;
      end
      hbb_pkg::ST_DREQ: begin
        mreq_d = 1'b1;
        mlock_d = lk_q;
        if (up_act && !owner && !(hmastlock_in && !lk_q)) begin
          hresp_d = hbb_pkg::HRESP_SPLIT;
          hready_d = 1'b0;
          queue_d[hmaster_in] = 1'b1;
        end else if (up_act && hmastlock_in && !req_q.write && !lk_q) begin
          // locked access preempts the pending read
          sav_d = req_q;
          sav_v_d = 1'b1;
          req_d = '{haddr_in, hwrite_in, hsize_in, hburst_in, hmaster_in, 1'b1, prefetch_in};
          lk_d = 1'b1;
          beats_d = beat_count(req_d);
        end
        if (mgrant_in && mready_in) begin
          maddr_d = req_q.addr;
          mwrite_d = req_q.write;
          msize_d = (req_q.size > hbb_pkg::HSIZE_WORD) ? hbb_pkg::HSIZE_WORD : req_q.size;
          mburst_d = (beats_q > 1) ? hbb_pkg::HBURST_INCR : hbb_pkg::HBURST_SINGLE;
          mtrans_d = hbb_pkg::HTRANS_NSEQ;
          st_d = hbb_pkg::ST_DADDR;
        end
      end
      hbb_pkg::ST_DADDR, hbb_pkg::ST_DDATA: begin
        if (up_act && !owner && !hmastlock_in) begin
          hresp_d = hbb_pkg::HRESP_SPLIT;
          hready_d = 1'b0;
          queue_d[hmaster_in] = 1'b1;
        end
        if (st_q == hbb_pkg::ST_DADDR) begin
          // one address phase per beat, held while mready_in is low
          mtrans_d = mready_in ? hbb_pkg::HTRANS_IDLE : mtrans_out;
          st_d = mready_in ? hbb_pkg::ST_DDATA : hbb_pkg::ST_DADDR;
        end else begin
          // non-prefetch reads hold the bus with busy between beats
          mtrans_d = (req_q.prefetch || req_q.write) ? hbb_pkg::HTRANS_IDLE
                     : hbb_pkg::HTRANS_BUSY;
        end
        if (mready_in && st_q == hbb_pkg::ST_DDATA) begin
          if (mresp_in == hbb_pkg::HRESP_SPLIT || mresp_in == hbb_pkg::HRESP_RETRY) begin
            mtrans_d = hbb_pkg::HTRANS_IDLE;
            st_d = hbb_pkg::ST_DREQ;
          end else begin
            err_d = err_q | (mresp_in == hbb_pkg::HRESP_ERROR);
            cnt_d = cnt_q + 1'b1;
            maddr_d = maddr_out + 32'(hbb_pkg::WORD_BYTES);
            mtrans_d = hbb_pkg::HTRANS_SEQ;
            st_d = hbb_pkg::ST_DADDR;
            if (cnt_q + 1'b1 >= beats_q) begin
              mtrans_d = hbb_pkg::HTRANS_IDLE;
              mreq_d = 1'b0;
              mlock_d = lk_q && req_q.write ? 1'b0 : mlock_out;
              rd_v_d = !req_q.write;
              st_d = req_q.write ? hbb_pkg::ST_IDLE : hbb_pkg::ST_READY;
              if (req_q.write && sav_v_q) begin
                req_d = sav_q;
                st_d = hbb_pkg::ST_DREQ;
              end
            end
          end
        end
      end
      hbb_pkg::ST_READY: begin
        // answer ready: let the owner back into arbitration
        hsplit_d[req_q.master] = !hsplit_out[req_q.master] && rd_v_q;
        if (up_act && owner && !hwrite_in) begin
          hrdata_d = buf_q[idx_q[AW-1:0]];
          hresp_d = err_q ? hbb_pkg::HRESP_ERROR : hbb_pkg::HRESP_OKAY;
          idx_d = idx_q + 1'b1;
          if (idx_q + 1'b1 >= cnt_q || req_q.burst == hbb_pkg::HBURST_SINGLE) begin
            rd_v_d = 1'b0;
            err_d = 1'b0;
            lk_d = 1'b0;
            mlock_d = 1'b0;
            if (sav_v_q && !(req_q.master == sav_q.master)) begin
              req_d = sav_q;
              sav_v_d = 1'b0;
              st_d = hbb_pkg::ST_DREQ;
            end else begin
              sav_v_d = 1'b0;
              st_d = hbb_pkg::ST_IDLE;
              // release every queued master at once
              for (int i = 0; i < 16; i++) begin
                if (queue_q[i]) begin
                  hsplit_d[i] = 1'b1;
                  queue_d[i] = 1'b0;
                end
              end
            end
          end
        end else if (up_act && !owner && !hmastlock_in) begin
          hresp_d = hbb_pkg::HRESP_SPLIT;
          hready_d = 1'b0;
          queue_d[hmaster_in] = 1'b1;
        end
      end
      default: begin
        st_d = hbb_pkg::ST_IDLE;
      end
    endcase
  end

  logic buf_wr_en;
  always_comb begin
    buf_wr_en = 1'b0;
    if ((st_q == hbb_pkg::ST_DDATA) && mready_in && !req_q.write &&
        (mresp_in == hbb_pkg::HRESP_OKAY || mresp_in == hbb_pkg::HRESP_ERROR)) begin
      buf_wr_en = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (buf_wr_en) begin
      buf_q[cnt_q[AW-1:0]] <= mrdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= hbb_pkg::ST_IDLE;
      req_q <= '0;
      sav_q <= '0;
      sav_v_q <= 1'b0;
      cnt_q <= '0;
      beats_q <= '0;
      idx_q <= '0;
      rd_v_q <= 1'b0;
      err_q <= 1'b0;
      wlat_q <= 1'b0;
      queue_q <= '0;
      lk_q <= 1'b0;
      hsplit_out <= '0;
      hready_out <= 1'b1;
      hresp_out <= hbb_pkg::HRESP_OKAY;
      hrdata_out <= '0;
      mbusreq_out <= 1'b0;
      mlock_out <= 1'b0;
      maddr_out <= '0;
      mtrans_out <= hbb_pkg::HTRANS_IDLE;
      mwrite_out <= 1'b0;
      msize_out <= '0;
      mburst_out <= '0;
      mwdata_out <= '0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      sav_q <= sav_d;
      sav_v_q <= sav_v_d;
      cnt_q <= cnt_d;
      beats_q <= beats_d;
      idx_q <= idx_d;
      rd_v_q <= rd_v_d;
      err_q <= err_d;
      wlat_q <= wlat_d;
      queue_q <= queue_d;
      lk_q <= lk_d;
      hsplit_out <= hsplit_d;
      hready_out <= hready_d;
      hresp_out <= hresp_d;
      hrdata_out <= hrdata_d;
      mbusreq_out <= mreq_d;
      mlock_out <= mlock_d;
      maddr_out <= maddr_d;
      mtrans_out <= mtrans_d;
      mwrite_out <= mwrite_d;
      msize_out <= msize_d;
      mburst_out <= mburst_d;
      mwdata_out <= mwdata_d;
    end
  end

  property p_read_split;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_q == hbb_pkg::ST_IDLE && up_act && !hwrite_in && !sav_v_q) |=>
      hresp_out == hbb_pkg::HRESP_SPLIT;
  endproperty
  a_read_split: assert property (p_read_split) else $error("read not split");

  property p_write_zero_wait;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_q == hbb_pkg::ST_IDLE && up_act && hwrite_in && !hmastlock_in) |=> hready_out;
  endproperty
  a_write_zero_wait: assert property (p_write_zero_wait) else $error("write waited");

  property p_lock_wait;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_q == hbb_pkg::ST_IDLE && up_act && hwrite_in && hmastlock_in) |=> !hready_out;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("locked write no wait");

  property p_single_read_latency;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_q == hbb_pkg::ST_DREQ && mgrant_in && mready_in && !req_q.write &&
     beats_q == 1) ##1 (mready_in && mresp_in == hbb_pkg::HRESP_OKAY)[*2] |=>
      (st_q == hbb_pkg::ST_READY);
  endproperty
  a_single_read_latency: assert property (p_single_read_latency)
    else $error("read data not ready");

  property p_lock_follows;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_q == hbb_pkg::ST_DREQ && lk_q) |=> mlock_out;
  endproperty
  a_lock_follows: assert property (p_lock_follows) else $error("downstream not locked");

  property p_fcfs_split;
    @(posedge clk_in) disable iff (sys_rst_in)
    (st_q == hbb_pkg::ST_DDATA && up_act && !owner && !hmastlock_in) |=>
      hresp_out == hbb_pkg::HRESP_SPLIT;
  endproperty
  a_fcfs_split: assert property (p_fcfs_split) else $error("other master not split");

  property p_beats_bound;
    @(posedge clk_in) disable iff (sys_rst_in)
    st_q == hbb_pkg::ST_DDATA |-> beats_q <= (AW + 1)'(FIFO_WORDS);
  endproperty
  a_beats_bound: assert property (p_beats_bound) else $error("burst too long");

  property p_no_burst_cross;
    @(posedge clk_in) disable iff (sys_rst_in)
    (mtrans_out == hbb_pkg::HTRANS_SEQ && !mwrite_out) |-> maddr_out[4:0] != 5'h00;
  endproperty
  a_no_burst_cross: assert property (p_no_burst_cross) else $error("crossed boundary");

  c_read: cover property (@(posedge clk_in) st_q == hbb_pkg::ST_READY);
  c_write: cover property (@(posedge clk_in) st_q == hbb_pkg::ST_WDATA);
  c_save: cover property (@(posedge clk_in) sav_v_q);
endmodule

// File: verilog/hbb_pkg.sv
// package: shared constants and carrier types for the ahb split bridge
package hbb_pkg;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_BUSY = 2'h1;
  localparam logic [1:0] HTRANS_NSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [1:0] HRESP_ERROR = 2'h1;
  localparam logic [1:0] HRESP_RETRY = 2'h2;
  localparam logic [1:0] HRESP_SPLIT = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR = 3'h1;
  localparam int BOUNDARY_BYTES = 32;
  localparam int BOUNDARY_WORDS = 8;
  localparam int WORD_BYTES = 4;
  // upstream request as captured on the address phase
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [2:0] size;
    logic [2:0] burst;
    logic [3:0] master;
    logic lock;
    logic prefetch;
  } hbb_req_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WDATA = 6'h02,
    ST_DREQ = 6'h04,
    ST_DADDR = 6'h08,
    ST_DDATA = 6'h10,
    ST_READY = 6'h20
  } hbb_state_t;
endpackage
